// ---- common/ctb_consts.svh ----
// Constants for the transmit buffer control block
`ifndef CTB_CONSTS_SVH
`define CTB_CONSTS_SVH
`define CTB_BIT_ARB_LOST 5
`define CTB_BIT_BUS_ERR  4
`define CTB_BIT_SEND_REQ 3
`define CTB_BIT_AUTO_RR  2
`define CTB_NUM_BUF      8
`define CTB_RST_FLAGS    8'h00
`endif

// ---- common/ctb_pkg.sv ----
// Types for the transmit buffer control block
`include "ctb_consts.svh"
package ctb_pkg;
	typedef logic [`CTB_NUM_BUF-1:0] ctb_mask_t;
	typedef enum logic [1:0] {
		CTB_IDLE = 2'b00,
		CTB_SEND = 2'b01
	} ctb_state_e;
	typedef struct packed {
		logic set_req;
		logic clr_req;
		logic auto_en;
	} ctb_sw_s;
	typedef struct packed {
		logic remote_hit;
		logic active;
		logic done_ok;
		logic bus_err;
		logic arb_lost;
	} ctb_eng_s;
endpackage

// ---- verification/ctb_can_node.sv ----
// Model of the protocol engine and the bus nodes beyond it
module ctb_can_node
	import ctb_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire ctb_mask_t  req_in,
	input  wire logic [1:0] mode_in,
	output ctb_mask_t       active_out,
	output ctb_mask_t       done_ok_out,
	output ctb_mask_t       bus_err_out,
	output ctb_mask_t       arb_lost_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Attempt: 4 busy cycles, outcome on the last, then a 4-cycle gap
	// ****
	// Mode 0 success, 1 bus error, 2 lost arbitration, 3 never starts
	int        cnt;
	ctb_mask_t sel;
	always @(negedge clk_in) begin
		active_out   <= '0;
		done_ok_out  <= '0;
		bus_err_out  <= '0;
		arb_lost_out <= '0;
		if (!rst_b_in) begin
			cnt <= 0;
		end else if (cnt == 0) begin
			sel <= req_in & (~req_in + 8'h01);
			if (|req_in && mode_in != 2'd3) begin
				cnt <= 1;
			end
		end else if (cnt < 5 && !(|(sel & req_in))) begin
			cnt <= 5;
		end else begin
			cnt <= (cnt == 8) ? 0 : cnt + 1;
			if (cnt < 5) begin
				active_out <= sel;
			end
			if (cnt == 4) begin
				done_ok_out  <= (mode_in == 2'd0) ? sel : '0;
				bus_err_out  <= (mode_in == 2'd1) ? sel : '0;
				arb_lost_out <= (mode_in == 2'd2) ? sel : '0;
			end
		end
	end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the transmit buffer control block
module tb_top
	import ctb_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk;
	logic       rst_b;
	logic [1:0] mode;
	ctb_mask_t  set_r, clr_r, auto_en, hit, act, done, berr, arb;
	ctb_mask_t  sr, ab, ef, af, ae;
	int         n_fail;
	int         n_tests;
	ctb_can_node node (.clk_in(clk), .rst_b_in(rst_b), .req_in(sr),
		.mode_in(mode), .active_out(act), .done_ok_out(done),
		.bus_err_out(berr), .arb_lost_out(arb));
	ctb_tx_ctl dut (.CLK_IN(clk), .RST_B_IN(rst_b), .SET_REQ_IN(set_r),
		.CLR_REQ_IN(clr_r), .AUTO_EN_IN(auto_en), .REMOTE_HIT_IN(hit),
		.ACTIVE_IN(act), .DONE_OK_IN(done), .BUS_ERR_IN(berr),
		.ARB_LOST_IN(arb), .SEND_REQUEST_OUT(sr), .ABORT_OUT(ab),
		.TX_BUS_ERROR_FLAG_OUT(ef), .ARBITRATION_LOST_FLAG_OUT(af),
		.AUTO_REMOTE_REPLY_ENABLE_OUT(ae));
	// ****
	// Shared tasks; inputs move only at falling edges
	// ****
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic results();
		$display("fails %0d checks %0d", n_fail, n_tests);
		if (n_fail == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string nm, ctb_mask_t e, ctb_mask_t g);
		n_tests++;
		if (g !== e) begin
			$display("[FAIL] %s exp %h got %h", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask
	// Bounded wait: 0 request gone, 1 error flag, 2 arbitration flag
	task automatic wt(int k);
		repeat (40) begin
			@(negedge clk);
			if ((k == 0 && sr[0] === 1'b0) || (k == 1 && ef[0] === 1'b1)
				|| (k == 2 && af[0] === 1'b1))
				return;
		end
		$display("[FAIL] wait %0d exp 1 got 0", k);
		n_fail++;
		results();
	endtask
	task automatic req(ctb_mask_t s, ctb_mask_t c);
		@(negedge clk);
		set_r = s;
		clr_r = c;
		@(negedge clk);
		set_r = '0;
		clr_r = '0;
	endtask
	task automatic t_fault(logic [1:0] m, int k);
		mode = m;
		req(8'h01, 8'h00);
		wt(k);
		chk("flag", 8'h01, (k == 1) ? ef : af);
		chk("req", 8'h01, sr);
		req(8'h00, 8'h01);
		chk("abort", 8'h01, ab);
		chk("req", 8'h00, sr);
		tick(1);
		chk("abort", 8'h00, ab);
		tick(8);
	endtask
	task automatic t_send();
		mode = 2'd0;
		req(8'h01, 8'h00);
		chk("req", 8'h01, sr);
		wt(0);
		chk("err", 8'h00, ef);
		chk("arb", 8'h00, af);
		tick(6);
	endtask
	// Withdraw the request while the engine is already sending
	task automatic t_abort();
		mode = 2'd0;
		req(8'h01, 8'h00);
		tick(1);
		req(8'h00, 8'h01);
		chk("abort", 8'h01, ab);
		chk("req", 8'h00, sr);
		tick(1);
		chk("abort", 8'h00, ab);
		tick(8);
		chk("req", 8'h00, sr);
		chk("err", 8'h00, ef);
		chk("arb", 8'h00, af);
	endtask
	task automatic t_remote(logic en);
		mode = 2'd3;
		auto_en = {7'b0, en};
		tick(1);
		hit = 8'h01;
		tick(1);
		hit = 8'h00;
		chk("auto", {7'b0, en}, ae);
		chk("req", {7'b0, en}, sr);
		req(8'h00, 8'h01);
		chk("abort", {7'b0, en}, ab);
		auto_en = 8'h00;
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		{set_r, clr_r, auto_en, hit} = '0;
		mode = 2'd0;
		rst_b = 1'b0;
		n_fail = 0;
		n_tests = 0;
		tick(10);
		rst_b = 1'b1;
		chk("req", 8'h00, sr);
		t_fault(2'd1, 1);
		t_fault(2'd2, 2);
		t_send();
		t_abort();
		t_remote(1'b1);
		t_remote(1'b0);
		results();
	end
endmodule

// ---- verilog/ctb_buf_ctl.sv ----
// Control and status bits of one transmit buffer
module ctb_buf_ctl
	import ctb_pkg::*;
(
	input  wire logic     clk_in,
	input  wire logic     rst_b_in,
	input  wire ctb_sw_s  sw_in,
	input  wire ctb_eng_s eng_in,
	output logic          send_request_out,
	output logic          abort_out,
	output logic          tx_bus_error_flag_out,
	output logic          arbitration_lost_flag_out,
	output logic          auto_remote_reply_enable_out
);
	logic send_req_ff;
	logic nxt_send_req;
	logic abort_ff;
	logic err_ff;
	logic arb_ff;
	logic auto_ff;
	logic state_busy;
	ctb_state_e state_ff;

	// ****************************************
	// Send request
	// ****************************************
	// Hardware sets win over a software clear in the same cycle
	always_comb begin
		nxt_send_req = send_req_ff;
		if (sw_in.clr_req)
			nxt_send_req = 1'b0;
		if (eng_in.done_ok)
			nxt_send_req = 1'b0;
		if (sw_in.set_req)
			nxt_send_req = 1'b1;
		if (eng_in.remote_hit && auto_ff)
			nxt_send_req = 1'b1;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			send_req_ff <= 1'b0;
		else
			send_req_ff <= nxt_send_req;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			auto_ff <= 1'b0;
		else
			auto_ff <= sw_in.auto_en;
	end

	// Abort pulse only when a pending request is really withdrawn;
	// a set in the same cycle keeps the request, so no abort then
	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			abort_ff <= 1'b0;
		else
			abort_ff <= sw_in.clr_req && send_req_ff
				&& !nxt_send_req;
	end

	// ****************************************
	// Transmit status
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			state_ff <= CTB_IDLE;
		else
			state_ff <= eng_in.active ? CTB_SEND : CTB_IDLE;
	end
	assign state_busy = (state_ff == CTB_SEND) || eng_in.active;

	// Flags reflect the last attempt; a new attempt starts them clean
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			err_ff <= 1'b0;
			arb_ff <= 1'b0;
		end else if (eng_in.active && state_ff == CTB_IDLE) begin
			err_ff <= eng_in.bus_err;
			arb_ff <= eng_in.arb_lost;
		end else if (state_busy) begin
			if (eng_in.bus_err)
				err_ff <= 1'b1;
			if (eng_in.arb_lost)
				arb_ff <= 1'b1;
		end
	end

	assign send_request_out             = send_req_ff;
	assign abort_out                    = abort_ff;
	assign tx_bus_error_flag_out        = err_ff;
	assign arbitration_lost_flag_out    = arb_ff;
	assign auto_remote_reply_enable_out = auto_ff;

	// ****************************************
	// Checks
	// ****************************************
	property p_done_clears;
		@(posedge clk_in) disable iff (!rst_b_in)
		(eng_in.done_ok && !sw_in.set_req
			&& !(eng_in.remote_hit && auto_ff)) |=> !send_req_ff;
	endproperty
	a_done_clears: assert property (p_done_clears)
		else $error("send request not cleared after success");

	property p_set_req;
		@(posedge clk_in) disable iff (!rst_b_in)
		sw_in.set_req |=> send_req_ff;
	endproperty
	a_set_req: assert property (p_set_req)
		else $error("send request not set by software");

	property p_abort;
		@(posedge clk_in) disable iff (!rst_b_in)
		(sw_in.clr_req && send_req_ff && !sw_in.set_req
			&& !(eng_in.remote_hit && auto_ff))
			|=> abort_ff ##1 !abort_ff;
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort not raised on withdrawn request");

	property p_abort_only;
		@(posedge clk_in) disable iff (!rst_b_in)
		abort_ff |-> !send_req_ff && $past(send_req_ff);
	endproperty
	a_abort_only: assert property (p_abort_only)
		else $error("abort raised without a withdrawn request");

	property p_auto_set;
		@(posedge clk_in) disable iff (!rst_b_in)
		(eng_in.remote_hit && auto_ff) |=> send_req_ff;
	endproperty
	a_auto_set: assert property (p_auto_set)
		else $error("remote frame did not set send request");

	property p_auto_off;
		@(posedge clk_in) disable iff (!rst_b_in)
		(eng_in.remote_hit && !auto_ff && !sw_in.set_req
			&& !sw_in.clr_req && !eng_in.done_ok)
			|=> send_req_ff == $past(send_req_ff);
	endproperty
	a_auto_off: assert property (p_auto_off)
		else $error("remote frame changed request while disabled");

	property p_err;
		@(posedge clk_in) disable iff (!rst_b_in)
		(eng_in.active && eng_in.bus_err) |=> err_ff;
	endproperty
	a_err: assert property (p_err)
		else $error("bus error flag not set");

	property p_arb;
		@(posedge clk_in) disable iff (!rst_b_in)
		(eng_in.active && eng_in.arb_lost) |=> arb_ff;
	endproperty
	a_arb: assert property (p_arb)
		else $error("arbitration lost flag not set");

	property p_clean_start;
		@(posedge clk_in) disable iff (!rst_b_in)
		(eng_in.active && state_ff == CTB_IDLE && !eng_in.bus_err
			&& !eng_in.arb_lost) |=> !err_ff && !arb_ff;
	endproperty
	a_clean_start: assert property (p_clean_start)
		else $error("flags not cleared at new attempt");
endmodule

// ---- verilog/ctb_tx_ctl.sv ----
// Transmit request control and status for all message buffers
`include "ctb_consts.svh"

module ctb_tx_ctl
	import ctb_pkg::*;
(
	input  wire logic      CLK_IN,
	input  wire logic      RST_B_IN,
	input  wire ctb_mask_t SET_REQ_IN,
	input  wire ctb_mask_t CLR_REQ_IN,
	input  wire ctb_mask_t AUTO_EN_IN,
	input  wire ctb_mask_t REMOTE_HIT_IN,
	input  wire ctb_mask_t ACTIVE_IN,
	input  wire ctb_mask_t DONE_OK_IN,
	input  wire ctb_mask_t BUS_ERR_IN,
	input  wire ctb_mask_t ARB_LOST_IN,
	output ctb_mask_t      SEND_REQUEST_OUT,
	output ctb_mask_t      ABORT_OUT,
	output ctb_mask_t      TX_BUS_ERROR_FLAG_OUT,
	output ctb_mask_t      ARBITRATION_LOST_FLAG_OUT,
	output ctb_mask_t      AUTO_REMOTE_REPLY_ENABLE_OUT
);
	// ****************************************
	// Per-buffer control
	// ****************************************
	// All inputs come from logic on this clock, so no synchronisers
	for (genvar i = 0; i < `CTB_NUM_BUF; i++) begin : g_buf
		ctb_sw_s  sw;
		ctb_eng_s eng;
		assign sw  = '{set_req: SET_REQ_IN[i], clr_req: CLR_REQ_IN[i],
			auto_en: AUTO_EN_IN[i]};
		assign eng = '{remote_hit: REMOTE_HIT_IN[i], active: ACTIVE_IN[i],
			done_ok: DONE_OK_IN[i], bus_err: BUS_ERR_IN[i],
			arb_lost: ARB_LOST_IN[i]};
		ctb_buf_ctl u_buf (
			.clk_in                       (CLK_IN),
			.rst_b_in                     (RST_B_IN),
			.sw_in                        (sw),
			.eng_in                       (eng),
			.send_request_out             (SEND_REQUEST_OUT[i]),
			.abort_out                    (ABORT_OUT[i]),
			.tx_bus_error_flag_out        (TX_BUS_ERROR_FLAG_OUT[i]),
			.arbitration_lost_flag_out    (ARBITRATION_LOST_FLAG_OUT[i]),
			.auto_remote_reply_enable_out (AUTO_REMOTE_REPLY_ENABLE_OUT[i])
		);
	end
endmodule
